// ===== rtl/dma_software_burst_request.sv
// Operation
// RULE_01 - Sixteen request bits sit in positions 15..0, bit n serving request number n.
// RULE_02 - A bit reads zero when no burst for that request number is in progress.
// RULE_03 - A bit reads one while the burst for that request number is running.
// RULE_04 - Writing zero to a bit does nothing: no cancel and no other change.
// RULE_05 - Writing one to a bit raises a burst request for that request number.
// RULE_06 - Software never requests a number whose hardware request is active.
// RULE_07 - Software keeps zero every bit whose request number cannot burst.
// RULE_08 - Software writes zeros to bits 31..16, which have no effect in the device.
`timescale 1ns/100ps
`include "dma_sbr_defines.svh"

module dma_software_burst_request (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Write address channel
    input  wire logic [`SBR_ADDR_W-1:0]   awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    // Write data channel
    input  wire logic [`SBR_DATA_W-1:0]   wdata,
    input  wire logic [`SBR_STRB_W-1:0]   wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    // Write response channel
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    // Read address channel
    input  wire logic [`SBR_ADDR_W-1:0]   araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    // Read data channel
    output logic [`SBR_DATA_W-1:0]        rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    // Transfer engine side
    output dma_sbr_pkg::req_vec_t         burst_req,
    input  wire dma_sbr_pkg::req_vec_t    burst_done,
    input  wire dma_sbr_pkg::req_vec_t    hw_req_active
);

    // Word-aligned form of a byte address
    function automatic logic [`SBR_ADDR_W-1:0] word_addr(input logic [`SBR_ADDR_W-1:0] a);
        word_addr = {a[`SBR_ADDR_W-1:`SBR_WORD_LSB], {`SBR_WORD_LSB{1'b0}}};
    endfunction

    // Byte strobes widened to a bit mask
    function automatic logic [`SBR_DATA_W-1:0] strb_mask(input logic [`SBR_STRB_W-1:0] s);
        logic [`SBR_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `SBR_STRB_W; i++) begin
            m[i*`SBR_BYTE_W +: `SBR_BYTE_W] = {`SBR_BYTE_W{s[i]}};
        end
        strb_mask = m;
    endfunction

    // Write channel state
    logic                        aw_held;
    logic [`SBR_ADDR_W-1:0]      held_addr;
    logic                        w_held;
    logic [`SBR_DATA_W-1:0]      held_data;
    logic [`SBR_STRB_W-1:0]      held_strb;
    logic                        next_aw_held;
    logic [`SBR_ADDR_W-1:0]      next_held_addr;
    logic                        next_w_held;
    logic [`SBR_DATA_W-1:0]      next_held_data;
    logic [`SBR_STRB_W-1:0]      next_held_strb;
    logic                        next_awready;
    logic                        next_wready;
    logic                        next_bvalid;
    logic [1:0]                  next_bresp;

    // Write decode
    logic                        aw_fire;
    logic                        w_fire;
    logic                        do_write;
    logic [`SBR_ADDR_W-1:0]      wr_addr;
    logic [`SBR_DATA_W-1:0]      wr_bits;
    logic                        hit_req;
    logic                        hit_conflict;
    dma_sbr_pkg::req_vec_t       set_mask;
    dma_sbr_pkg::req_vec_t       conflict_clr;

    // Read channel state
    logic                        ar_fire;
    logic                        next_arready;
    logic                        next_rvalid;
    logic [`SBR_DATA_W-1:0]      next_rdata;
    logic [1:0]                  next_rresp;

    // Misuse record: request written while hardware asked for the same number
    dma_sbr_pkg::req_vec_t       conflict;
    dma_sbr_pkg::req_vec_t       next_conflict;

    always_comb begin
        aw_fire        = awvalid && awready;
        w_fire         = wvalid && wready;
        wr_addr        = aw_held ? held_addr : awaddr;
        wr_bits        = (w_held ? held_data : wdata) & strb_mask(w_held ? held_strb : wstrb);
        // Response slot must be free so no answer is overwritten
        do_write       = (aw_held || aw_fire) && (w_held || w_fire) && !bvalid;
        hit_req        = 1'b0;
        hit_conflict   = 1'b0;
        if (word_addr(wr_addr) == `SBR_REQ_OFFSET) begin
            hit_req = do_write;
        end else if (word_addr(wr_addr) == `SBR_CONFLICT_OFFSET) begin
            hit_conflict = do_write;
        end
        // Only ones land; zeros and bits 31..16 are dropped here
        set_mask       = hit_req ? wr_bits[`SBR_REQ_COUNT-1:0] : `SBR_REQ_RESET; // [RULE_05] [RULE_04] [RULE_08]
        conflict_clr   = hit_conflict ? wr_bits[`SBR_REQ_COUNT-1:0] : `SBR_CONFLICT_RESET;

        next_aw_held   = (aw_held || aw_fire) && !do_write;
        next_held_addr = aw_fire ? awaddr : held_addr;
        next_w_held    = (w_held || w_fire) && !do_write;
        next_held_data = w_fire ? wdata : held_data;
        next_held_strb = w_fire ? wstrb : held_strb;
        next_awready   = !next_aw_held;
        next_wready    = !next_w_held;

        next_bvalid    = bvalid;
        next_bresp     = bresp;
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp  = (hit_req || hit_conflict) ? dma_sbr_pkg::RESP_OKAY
                                                    : dma_sbr_pkg::RESP_DECERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held   <= 1'b0;
            held_addr <= '0;
            w_held    <= 1'b0;
            held_data <= `SBR_RDATA_RESET;
            held_strb <= '0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= dma_sbr_pkg::RESP_OKAY;
        end else begin
            aw_held   <= next_aw_held;
            held_addr <= next_held_addr;
            w_held    <= next_w_held;
            held_data <= next_held_data;
            held_strb <= next_held_strb;
            awready   <= next_awready;
            wready    <= next_wready;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
        end
    end

    // Per-number running flag; completion from the engine clears it
    sw_burst_req_bank u_bank (
        .clk        (clk),
        .rst        (rst),
        .set_mask   (set_mask),
        .clear_mask (burst_done),
        .pending    (burst_req)
    ); // [RULE_01] [RULE_03] [RULE_05]

    // Sticky misuse flags, write one to clear, new event wins over the clear
    always_comb begin
        next_conflict = (conflict & ~conflict_clr) | (set_mask & hw_req_active); // [RULE_06]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conflict <= `SBR_CONFLICT_RESET;
        end else begin
            conflict <= next_conflict;
        end
    end

    // Read path: one outstanding read, data frozen until taken
    always_comb begin
        ar_fire     = arvalid && arready;
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (ar_fire) begin
            next_rvalid = 1'b1;
            if (word_addr(araddr) == `SBR_REQ_OFFSET) begin
                next_rdata = {`SBR_UPPER_ZERO, burst_req}; // [RULE_02] [RULE_03] [RULE_01]
                next_rresp = dma_sbr_pkg::RESP_OKAY;
            end else if (word_addr(araddr) == `SBR_CONFLICT_OFFSET) begin
                next_rdata = {`SBR_UPPER_ZERO, conflict};
                next_rresp = dma_sbr_pkg::RESP_OKAY;
            end else begin
                next_rdata = `SBR_RDATA_RESET;
                next_rresp = dma_sbr_pkg::RESP_DECERR;
            end
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= `SBR_RDATA_RESET;
            rresp   <= dma_sbr_pkg::RESP_OKAY;
        end else begin
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_write_one_raises;
        (set_mask != `SBR_REQ_RESET) |=> ((burst_req & $past(set_mask)) == $past(set_mask));
    endproperty
    a_write_one_raises: assert property (p_write_one_raises) // [RULE_05]
        else $error("written request bit did not rise");

    property p_no_rise_without_one;
        ##1 ((~$past(burst_req) & burst_req & ~$past(set_mask)) == `SBR_REQ_RESET);
    endproperty
    a_no_rise_without_one: assert property (p_no_rise_without_one) // [RULE_04]
        else $error("request bit rose without a written one");

    property p_no_fall_without_done;
        ##1 (($past(burst_req) & ~burst_req & ~$past(burst_done)) == `SBR_REQ_RESET);
    endproperty
    a_no_fall_without_done: assert property (p_no_fall_without_done) // [RULE_04]
        else $error("request bit fell without completion");

    property p_done_clears;
        ((burst_done & ~set_mask) != `SBR_REQ_RESET)
            |=> ((burst_req & $past(burst_done & ~set_mask)) == `SBR_REQ_RESET);
    endproperty
    a_done_clears: assert property (p_done_clears) // [RULE_02]
        else $error("finished burst still reads as running");

    property p_read_shows_running;
        (ar_fire && word_addr(araddr) == `SBR_REQ_OFFSET)
            |=> (rvalid && rdata == {`SBR_UPPER_ZERO, $past(burst_req)}
                 && rresp == dma_sbr_pkg::RESP_OKAY);
    endproperty
    a_read_shows_running: assert property (p_read_shows_running) // [RULE_03]
        else $error("read data differ from running flags");

    property p_upper_reads_zero;
        (rvalid && rresp == dma_sbr_pkg::RESP_OKAY)
            |-> (rdata[`SBR_DATA_W-1:`SBR_REQ_COUNT] == `SBR_UPPER_ZERO);
    endproperty
    a_upper_reads_zero: assert property (p_upper_reads_zero) // [RULE_01]
        else $error("bits above request field read nonzero");

    property p_rdata_held;
        (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp));
    endproperty
    a_rdata_held: assert property (p_rdata_held)
        else $error("read answer changed before it was taken");

    property p_write_answered;
        ((awvalid && awready) && (wvalid && wready) && !bvalid)
            |=> (bvalid && awready && wready);
    endproperty
    a_write_answered: assert property (p_write_answered)
        else $error("write not answered one cycle after both channels taken");

    property p_req_write_okay;
        (do_write && word_addr(wr_addr) == `SBR_REQ_OFFSET)
            |=> (bvalid && bresp == dma_sbr_pkg::RESP_OKAY);
    endproperty
    a_req_write_okay: assert property (p_req_write_okay) // [RULE_05]
        else $error("request write not answered OKAY");

    property p_running_holds;
        ((burst_req & ~burst_done) != `SBR_REQ_RESET)
            |=> ((burst_req & $past(burst_req & ~burst_done)) == $past(burst_req & ~burst_done));
    endproperty
    a_running_holds: assert property (p_running_holds) // [RULE_03]
        else $error("running burst dropped before completion");

    property p_unmapped_write;
        (do_write && word_addr(wr_addr) != `SBR_REQ_OFFSET
                  && word_addr(wr_addr) != `SBR_CONFLICT_OFFSET)
            |=> (bvalid && bresp == dma_sbr_pkg::RESP_DECERR
                 && burst_req == ($past(burst_req) & ~$past(burst_done)));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped write changed state or was not refused");

    property p_unmapped_read;
        (ar_fire && word_addr(araddr) != `SBR_REQ_OFFSET
                 && word_addr(araddr) != `SBR_CONFLICT_OFFSET)
            |=> (rvalid && rdata == `SBR_RDATA_RESET && rresp == dma_sbr_pkg::RESP_DECERR);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not refused with zero data");

    property p_misuse_read;
        (ar_fire && word_addr(araddr) == `SBR_CONFLICT_OFFSET)
            |=> (rvalid && rdata == {`SBR_UPPER_ZERO, $past(conflict)}
                 && rresp == dma_sbr_pkg::RESP_OKAY);
    endproperty
    a_misuse_read: assert property (p_misuse_read) // [RULE_06]
        else $error("misuse status read differs from flags");

    // Only one read answer may be outstanding
    property p_read_busy_refused;
        rvalid |-> !arready;
    endproperty
    a_read_busy_refused: assert property (p_read_busy_refused)
        else $error("read address accepted while an answer is pending");

endmodule

// ===== rtl/dma_sbr_defines.svh
`ifndef DMA_SBR_DEFINES_SVH
`define DMA_SBR_DEFINES_SVH

// Bus geometry
`define SBR_ADDR_W          12
`define SBR_DATA_W          32
`define SBR_STRB_W          4
`define SBR_WORD_LSB        2
`define SBR_BYTE_W          8

// Request numbers
`define SBR_REQ_COUNT       16

// Register byte offsets
`define SBR_REQ_OFFSET      12'h000
`define SBR_CONFLICT_OFFSET 12'h004

// Reset values
`define SBR_REQ_RESET       16'h0000
`define SBR_CONFLICT_RESET  16'h0000
`define SBR_RDATA_RESET     32'h0000_0000
`define SBR_UPPER_ZERO      16'h0000

`endif

// ===== rtl/dma_sbr_pkg.sv
`include "dma_sbr_defines.svh"

package dma_sbr_pkg;

    typedef logic [`SBR_REQ_COUNT-1:0] req_vec_t;

    // Encodings follow enum order: 0..3
    typedef enum logic [1:0] {
        RESP_OKAY,
        RESP_EXOKAY,
        RESP_SLVERR,
        RESP_DECERR
    } axi_resp_t;

endpackage

// ===== rtl/sw_burst_req_bank.sv
`timescale 1ns/100ps
`include "dma_sbr_defines.svh"

module sw_burst_req_bank (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Updates
    input  wire dma_sbr_pkg::req_vec_t set_mask,
    input  wire dma_sbr_pkg::req_vec_t clear_mask,
    // State
    output dma_sbr_pkg::req_vec_t    pending
);

    dma_sbr_pkg::req_vec_t next_pending;

    // A new request beats a completion landing in the same cycle
    always_comb begin
        next_pending = (pending & ~clear_mask) | set_mask;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= `SBR_REQ_RESET;
        end else begin
            pending <= next_pending;
        end
    end

endmodule

// ===== tb/dma_software_burst_request_bench.sv
`timescale 1ns/100ps
`include "dma_sbr_defines.svh"

module dma_software_burst_request_bench;
    localparam int          LIMIT    = 20000;
    localparam logic [15:0] NO_BURST = 16'h0000; // Every number can burst here
    logic                  clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic [11:0]           awaddr, araddr;
    logic [31:0]           wdata, rdata, d;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    dma_sbr_pkg::req_vec_t burst_req, burst_done, hw_req_active, hw, m, exp_run;
    logic [33:0]           rq[$];
    logic [1:0]            bq[$];
    int                    num_errors, checks_done, cycles, seed;

    dma_software_burst_request dma_software_burst_request_i (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .burst_req(burst_req), .burst_done(burst_done), .hw_req_active(hw_req_active)
    );

    task automatic chk_val(input string what, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task final_report;
        $display("Compared %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Both channels offered together, each released at its own acceptance
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_t, w_t;
        @(posedge clk);
        bq.push_back(er);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_t = 1'b0;
        w_t  = 1'b0;
        while (!(aw_t && w_t)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_t = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_t = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        rq.push_back({ed, er});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // One-cycle completion pulse from the engine side
    task automatic fin(input dma_sbr_pkg::req_vec_t v);
        @(posedge clk);
        burst_done <= v;
        @(posedge clk);
        burst_done <= 16'h0000;
        @(posedge clk);
        exp_run = exp_run & ~v;
    endtask

    always @(posedge clk) begin
        if (!rst && rvalid && rready && rq.size() > 0)
            chk_val("read", rq.pop_front(), {rdata, rresp});
        if (!rst && bvalid && bready && bq.size() > 0)
            chk_val("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            final_report;
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
        {burst_done, hw_req_active, exp_run} = 48'h0;
        num_errors  = 0;
        checks_done = 0;
        cycles      = 0;
        seed = 75266;
        rst  = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(`SBR_REQ_OFFSET, 32'h0, 2'h0);
        chk_val("burst_req", 34'h0, {18'h0, burst_req});
        $display("Test reset done");
        for (int n = 0; n < 16; n++) begin
            wr(`SBR_REQ_OFFSET, {16'h0, 16'h1 << n}, 4'hF, 2'h0);
            exp_run = 16'h1 << n;
            chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
            fin(exp_run);
            rd(`SBR_REQ_OFFSET, 32'h0, 2'h0);
        end
        $display("Test walking bit done");
        repeat (8) begin
            hw = 16'($random(seed));
            hw_req_active <= hw;
            d = $random(seed);
            d[31:16] = `SBR_UPPER_ZERO;
            d[15:0] = d[15:0] & ~hw & ~NO_BURST;
            wr(`SBR_REQ_OFFSET, d, 4'hF, 2'h0);
            exp_run = exp_run | d[15:0];
            chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
            d = $random(seed);
            wr(`SBR_REQ_OFFSET, 32'h0, d[3:0], 2'h0);
            chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
            rd(`SBR_REQ_OFFSET, {16'h0, exp_run}, 2'h0);
            m = 16'($random(seed));
            fin(m & exp_run);
            chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
        end
        $display("Test random requests done");
        rd(`SBR_CONFLICT_OFFSET, 32'h0, 2'h0);
        wr(`SBR_CONFLICT_OFFSET, 32'h0000_FFFF, 4'hF, 2'h0);
        hw_req_active <= 16'h0000;
        fin(exp_run);
        wr(`SBR_REQ_OFFSET, 32'h0000_FFFF, 4'h2, 2'h0);
        exp_run = 16'hFF00 & ~NO_BURST;
        chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
        wr(12'h010, 32'h0000_00FF, 4'hF, 2'h3);
        chk_val("burst_req", {18'h0, exp_run}, {18'h0, burst_req});
        rd(12'h010, 32'h0, 2'h3);
        fin(exp_run);
        rd(`SBR_REQ_OFFSET, 32'h0, 2'h0);
        $display("Test strobe and unmapped done");
        final_report;
    end
endmodule
